// ==== logic/sdcb_bridge.sv ====
// Single dword completer bridge: request receive, fabric master, completion, interrupts
`timescale 1ns/10ps
// Notes on behaviour
// - Fabric master data path is 32 bits wide.
// - One request at a time; new requests refused until the current finishes.
// - Memory reads and writes of exactly one dword are serviced.
// - Read longer than four bytes gets a Completer Abort completion, no read.
// - Write longer than four bytes is dropped with no completion, only the drop event flagged, no fabric access.
// - Other unsupported non-posted requests get Completer Abort with no data.
// - Accepted header fields go to the master, which issues the fabric access.
// - During a read, ready stays low until the completion is delivered.
// - During a write, the fabric write issues before the next request is taken.
// - Every byte-enable pattern passes through to the slave on writes; on reads only nonzero patterns do.
// - Zero-length read gets Completer Abort; one dword read with zero byte enables (flush) gets a proper completion.
// - Message enable bit 16 at 0x050 selects MSI when set, else INTx.
// - Exactly one interrupt input from the fabric is taken.
// - With MSI off and legacy disable set, no INTx assert messages are sent; a deassert for an asserted line still goes out.

module sdcb_bridge #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 32
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // Request side from the transaction layer
    input  wire logic              req_valid,
    input  wire sdcb_pkg::sdcb_req_e req_kind,
    input  wire logic [9:0]        req_len_dw,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [3:0]        req_first_be,
    input  wire logic [15:0]       req_id,
    input  wire logic [7:0]        req_tag,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   req_ready,
    // Completion side to the transaction layer
    output logic                   cpl_valid,
    output logic [2:0]             cpl_status,
    output logic                   cpl_has_data,
    output logic [15:0]            cpl_req_id,
    output logic [7:0]             cpl_tag,
    output logic [DATA_W-1:0]      cpl_data,
    input  wire logic              cpl_ready,
    // Fabric master
    output logic [ADDR_W-1:0]      fm_address,
    output logic [3:0]             fm_byteenable,
    output logic                   fm_read,
    output logic                   fm_write,
    output logic [DATA_W-1:0]      fm_writedata,
    input  wire logic [DATA_W-1:0] fm_readdata,
    input  wire logic              fm_readdatavalid,
    input  wire logic              fm_waitrequest,
    // Interrupt source and delivery
    input  wire logic              irq_in,
    output logic                   msi_req,
    input  wire logic              msi_ack,
    output logic                   intx_assert,
    output logic                   intx_deassert,
    output logic                   irq_out,
    // Local register port
    input  wire logic [11:0]       reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata
);

    // ******************************************
    // State
    // ******************************************
    typedef enum logic [2:0] {
        SDCB_IDLE,
        SDCB_FAB_WR,
        SDCB_FAB_RD,
        SDCB_RD_WAIT,
        SDCB_CPL
    } sdcb_st_e;

    typedef struct packed {
        // Request and completion
        sdcb_st_e             st;
        logic                 req_ready;
        logic                 cpl_valid;
        logic [2:0]           cpl_status;
        logic                 cpl_has_data;
        logic [15:0]          cpl_req_id;
        logic [7:0]           cpl_tag;
        logic [DATA_W-1:0]    cpl_data;

        // Fabric master
        logic [ADDR_W-1:0]    fm_address;
        logic [3:0]           fm_byteenable;
        logic                 fm_read;
        logic                 fm_write;
        logic [DATA_W-1:0]    fm_writedata;

        // Configuration and event registers
        logic [15:0]          cmd;
        logic [31:0]          msi_ctrl;
        logic [sdcb_pkg::EV_W-1:0] ev_stat;
        logic [sdcb_pkg::EV_W-1:0] ev_en;

        // Interrupt delivery and register read
        logic                 irq_out;
        logic                 irq_prev;
        logic                 intx_level;
        logic                 msi_req;
        logic                 intx_assert;
        logic                 intx_deassert;
        logic [31:0]          reg_rdata;
    } sdcb_state_s;

    sdcb_state_s s_q;
    sdcb_state_s s_d;

    // ******************************************
    // Decode helpers
    // ******************************************
    // Single dword length check, shared by the write and read request decodes
    function automatic logic one_dw(input logic [9:0] n);
        return n == sdcb_pkg::DW_ONE;
    endfunction : one_dw

    // Read request check, used by both read paths
    function automatic logic is_rd(input sdcb_pkg::sdcb_req_e k);
        return k == sdcb_pkg::SDCB_REQ_RD;
    endfunction : is_rd

    // Register read mux, shared by the read path
    function automatic logic [31:0] rd_mux(input logic [11:0] a, input sdcb_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == sdcb_pkg::CMD_OFS)
            v = {16'h0000, s.cmd};
        else if (a == sdcb_pkg::MSI_CTRL_OFS)
            v = s.msi_ctrl;
        else if (a == sdcb_pkg::IRQ_STAT_OFS)
            v = {{(32-sdcb_pkg::EV_W){1'b0}}, s.ev_stat};
        else if (a == sdcb_pkg::IRQ_EN_OFS)
            v = {{(32-sdcb_pkg::EV_W){1'b0}}, s.ev_en};
        else if (a == sdcb_pkg::BR_STAT_OFS)
            v = {29'h0000_0000, s.st};
        return v;
    endfunction : rd_mux

    // ******************************************
    // Next state
    // ******************************************
    always_comb
    begin
        logic [sdcb_pkg::EV_W-1:0] ev_set;
        logic [sdcb_pkg::EV_W-1:0] ev_clr;
        logic                      msi_on;
        logic                      intx_off;
        logic                      take;

        ev_set   = '0;
        ev_clr   = '0;
        s_d      = s_q;
        msi_on   = s_q.msi_ctrl[sdcb_pkg::MSI_EN_BIT];
        intx_off = s_q.cmd[sdcb_pkg::CMD_INTX_DIS_BIT];
        take     = req_valid && s_q.req_ready;

        s_d.intx_assert   = 1'b0;
        s_d.intx_deassert = 1'b0;

        // ******************************************
        // Request state machine
        // ******************************************
        // Request handling, one at a time
        case (s_q.st)
            SDCB_IDLE:
            begin
                s_d.req_ready = 1'b1;
                if (take)
                begin
                    s_d.req_ready     = 1'b0;
                    s_d.cpl_req_id    = req_id;
                    s_d.cpl_tag       = req_tag;
                    s_d.fm_address    = req_addr;
                    s_d.fm_byteenable = req_first_be;
                    s_d.fm_writedata  = req_data;
                    if (req_kind == sdcb_pkg::SDCB_REQ_WR)
                    begin
                        if (one_dw(req_len_dw))
                        begin
                            s_d.fm_write = 1'b1;
                            s_d.st       = SDCB_FAB_WR;
                        end
                        else
                        begin
                            ev_set[sdcb_pkg::EV_DROP] = 1'b1;
                            // Ready returns next cycle from the idle default
                        end
                    end
                    else if (is_rd(req_kind) && one_dw(req_len_dw)
                             && req_first_be != 4'h0)
                    begin
                        s_d.fm_read = 1'b1;
                        s_d.st      = SDCB_FAB_RD;
                    end
                    else if (is_rd(req_kind) && one_dw(req_len_dw))
                    begin
                        // Flush: no fabric access needed, data meaningless
                        s_d.cpl_valid    = 1'b1;
                        s_d.cpl_status   = sdcb_pkg::CPL_SC;
                        s_d.cpl_has_data = 1'b1;
                        s_d.cpl_data     = '0;
                        s_d.st           = SDCB_CPL;
                    end
                    else
                    begin
                        s_d.cpl_valid    = 1'b1;
                        s_d.cpl_status   = sdcb_pkg::CPL_CA;
                        s_d.cpl_has_data = 1'b0;
                        ev_set[sdcb_pkg::EV_ABORT] = 1'b1;
                        s_d.st           = SDCB_CPL;
                    end
                end
            end

            // Posted write: nothing goes back to the host
            SDCB_FAB_WR:
            begin
                if (!fm_waitrequest)
                begin
                    s_d.fm_write  = 1'b0;
                    s_d.req_ready = 1'b1;
                    s_d.st        = SDCB_IDLE;
                end
            end

            SDCB_FAB_RD:
            begin
                if (!fm_waitrequest)
                begin
                    s_d.fm_read = 1'b0;
                    s_d.st      = SDCB_RD_WAIT;
                end
            end

            // No timeout: a slave that never answers holds the bridge here
            SDCB_RD_WAIT:
            begin
                if (fm_readdatavalid)
                begin
                    s_d.cpl_valid    = 1'b1;
                    s_d.cpl_status   = sdcb_pkg::CPL_SC;
                    s_d.cpl_has_data = 1'b1;
                    s_d.cpl_data     = fm_readdata;
                    s_d.st           = SDCB_CPL;
                end
            end

            // Ready stays low while the completion waits, so no request overtakes it
            SDCB_CPL:
            begin
                if (cpl_ready)
                begin
                    s_d.cpl_valid = 1'b0;
                    s_d.req_ready = 1'b1;
                    s_d.st        = SDCB_IDLE;
                end
            end

            default:
            begin
                s_d.st = SDCB_IDLE;
            end
        endcase

        // ******************************************
        // Interrupt delivery
        // ******************************************
        // Single interrupt source, edges tracked for MSI messages, level for legacy messages
        s_d.irq_prev = irq_in;
        if (msi_on)
        begin
            if (irq_in && !s_q.irq_prev && !s_q.msi_req)
            begin
                s_d.msi_req = 1'b1;
                ev_set[sdcb_pkg::EV_MSI] = 1'b1;
            end
        end
        else if (!intx_off || s_q.intx_level)
        begin
            // A disable while asserted still lets the deassert out, avoiding a stuck line
            if (irq_in && !s_q.intx_level && !intx_off)
            begin
                s_d.intx_assert = 1'b1;
                s_d.intx_level  = 1'b1;
                ev_set[sdcb_pkg::EV_INTX] = 1'b1;
            end
            else if (s_q.intx_level && (!irq_in || intx_off))
            begin
                s_d.intx_deassert = 1'b1;
                s_d.intx_level    = 1'b0;
            end
        end
        if (s_q.msi_req && msi_ack)
            s_d.msi_req = 1'b0;

        // ******************************************
        // Register port
        // ******************************************
        // Register port; MSI settings take effect one cycle after the write
        if (reg_wr)
        begin
            if (reg_addr == sdcb_pkg::CMD_OFS)
                s_d.cmd = reg_wdata[15:0];
            else if (reg_addr == sdcb_pkg::MSI_CTRL_OFS)
                s_d.msi_ctrl = reg_wdata;
            else if (reg_addr == sdcb_pkg::IRQ_CLR_OFS)
                ev_clr = reg_wdata[sdcb_pkg::EV_W-1:0];
            else if (reg_addr == sdcb_pkg::IRQ_EN_OFS)
                s_d.ev_en = reg_wdata[sdcb_pkg::EV_W-1:0];
        end
        s_d.reg_rdata = reg_rd ? rd_mux(reg_addr, s_q) : 32'h0000_0000;

        // ******************************************
        // Event status and interrupt output
        // ******************************************
        // Set wins over clear
        s_d.ev_stat = (s_q.ev_stat & ~ev_clr) | ev_set;
        s_d.irq_out = |(s_d.ev_stat & s_d.ev_en);
    end

    // ******************************************
    // Register stage
    // ******************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q          <= '0;
            s_q.st       <= SDCB_IDLE;
            // Legacy delivery, not disabled, until software programs it
            s_q.cmd      <= sdcb_pkg::CMD_RST;
            s_q.msi_ctrl <= sdcb_pkg::MSI_CTRL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ******************************************
    // Outputs straight from flip-flops
    // ******************************************
    assign req_ready     = s_q.req_ready;
    assign cpl_valid     = s_q.cpl_valid;
    assign cpl_status    = s_q.cpl_status;
    assign cpl_has_data  = s_q.cpl_has_data;
    assign cpl_req_id    = s_q.cpl_req_id;
    assign cpl_tag       = s_q.cpl_tag;
    assign cpl_data      = s_q.cpl_data;
    assign fm_address    = s_q.fm_address;
    assign fm_byteenable = s_q.fm_byteenable;
    assign fm_read       = s_q.fm_read;
    assign fm_write      = s_q.fm_write;
    assign fm_writedata  = s_q.fm_writedata;

    // ******************************************
    // Interrupt and register port outputs
    // ******************************************
    assign msi_req       = s_q.msi_req;
    assign intx_assert   = s_q.intx_assert;
    assign intx_deassert = s_q.intx_deassert;
    assign irq_out       = s_q.irq_out;
    assign reg_rdata     = s_q.reg_rdata;

endmodule : sdcb_bridge

// ==== logic/sdcb_pkg.sv ====
// Package of constants for the single dword completer bridge
package sdcb_pkg;

    // ******************************************
    // Register map of the local register port
    // ******************************************
    localparam logic [11:0] CMD_OFS       = 12'h004;
    localparam logic [11:0] MSI_CTRL_OFS  = 12'h050;
    localparam logic [11:0] IRQ_STAT_OFS  = 12'h100;
    localparam logic [11:0] IRQ_CLR_OFS   = 12'h104;
    localparam logic [11:0] IRQ_EN_OFS    = 12'h108;
    localparam logic [11:0] BR_STAT_OFS   = 12'h10C;

    // ******************************************
    // Field positions and reset values
    // ******************************************
    localparam int          CMD_INTX_DIS_BIT = 10;
    localparam int          MSI_EN_BIT       = 16;
    localparam logic [15:0] CMD_RST          = 16'h0000;
    localparam logic [31:0] MSI_CTRL_RST     = 32'h0000_0000;
    localparam int          EV_W             = 4;
    localparam int          EV_ABORT         = 0;
    localparam int          EV_DROP          = 1;
    localparam int          EV_MSI           = 2;
    localparam int          EV_INTX          = 3;

    // ******************************************
    // Request kinds and completion status
    // ******************************************
    typedef enum logic [1:0] {
        SDCB_REQ_RD,
        SDCB_REQ_WR,
        SDCB_REQ_OTHER_NP
    } sdcb_req_e;

    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_CA = 3'h4;
    localparam logic [9:0] DW_ONE = 10'h001;

endpackage : sdcb_pkg

// ==== verif/sdcb_bridge_properties.sv ====
// Port-level checker for the single dword completer bridge
`timescale 1ns/10ps
module sdcb_bridge_properties (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                req_valid,
    input wire sdcb_pkg::sdcb_req_e req_kind,
    input wire logic [9:0]          req_len_dw,
    input wire logic [3:0]          req_first_be,
    input wire logic                req_ready,
    input wire logic                cpl_valid,
    input wire logic [2:0]          cpl_status,
    input wire logic                cpl_has_data,
    input wire logic                cpl_ready,
    input wire logic [3:0]          fm_byteenable,
    input wire logic                fm_read,
    input wire logic                fm_write,
    input wire logic                fm_waitrequest,
    input wire logic                irq_in,
    input wire logic                intx_assert,
    input wire logic                intx_deassert
);
    // ******************************************
    // Request and completion relations
    // ******************************************
    logic tk;
    logic one;
    assign tk = req_valid && req_ready;
    assign one = req_len_dw == sdcb_pkg::DW_ONE;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_one_at_time: assert property (tk |=> !req_ready) else $error("second request taken");
    a_long_read_abort: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_RD && !one
        |=> cpl_valid && cpl_status == sdcb_pkg::CPL_CA && !fm_read) else $error("long read not aborted");
    a_long_write_drop: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_WR && !one
        |=> (!fm_write && !cpl_valid) [*2]) else $error("long write not dropped");
    a_other_np_abort: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_OTHER_NP
        |=> cpl_valid && cpl_status == sdcb_pkg::CPL_CA && !cpl_has_data) else $error("bad abort");
    a_flush_done: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_RD && one && req_first_be == 4'h0
        |=> cpl_valid && cpl_status == sdcb_pkg::CPL_SC && !fm_read) else $error("flush not completed");
    a_read_be_pass: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_RD && one && req_first_be != 4'h0
        |=> fm_read && fm_byteenable == $past(req_first_be)) else $error("read not issued");
    a_write_be_pass: assert property (tk && req_kind == sdcb_pkg::SDCB_REQ_WR && one
        |=> fm_write && fm_byteenable == $past(req_first_be)) else $error("write not issued");
    a_ready_held_low: assert property ((fm_read || fm_write || cpl_valid) |-> !req_ready)
        else $error("ready during transfer");
    a_cpl_stands: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_status))
        else $error("completion dropped");
    a_intx_tracks: assert property (intx_assert |-> irq_in && !intx_deassert)
        else $error("assert without source");
    a_intx_release: assert property (intx_deassert |-> !irq_in) else $error("deassert with source");

    c_read: cover property (tk && req_kind == sdcb_pkg::SDCB_REQ_RD ##1 fm_read);
    c_stall: cover property (fm_write && fm_waitrequest);
    c_intx: cover property (intx_assert);
endmodule : sdcb_bridge_properties

bind sdcb_bridge sdcb_bridge_properties i_props (.*);

// ==== verif/sdcb_fabric_model.sv ====
// Fabric slave model with programmable wait states
`timescale 1ns/10ps
module sdcb_fabric_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  stall,
    input  wire logic [31:0] fm_address,
    input  wire logic [3:0]  fm_byteenable,
    input  wire logic        fm_read,
    input  wire logic        fm_write,
    input  wire logic [31:0] fm_writedata,
    output logic [31:0]      fm_readdata,
    output logic             fm_readdatavalid,
    output logic             fm_waitrequest,
    output logic [3:0]       last_be,
    output logic [7:0]       wr_cnt
);
    // ******************************************
    // Slave storage and wait states
    // ******************************************
    logic [31:0] mem [16];
    logic [3:0]  wait_q;
    logic        take;
    assign take = (fm_read || fm_write) && wait_q == stall;
    assign fm_waitrequest = (fm_read || fm_write) && !take;
    always_ff @(posedge clk)
    begin
        fm_readdatavalid <= 1'b0;
        // Idle read bus keeps toggling so stale data never looks valid
        fm_readdata <= ~fm_readdata;
        if (rst)
        begin
            for (int k = 0; k < 16; k++) mem[k] <= 32'h0;
            fm_readdata <= 32'h5A5A_5A5A;
            wait_q <= 4'h0;
            wr_cnt <= 8'h00;
            last_be <= 4'h0;
        end
        else if (take)
        begin
            wait_q <= 4'h0;
            last_be <= fm_byteenable;
            fm_readdatavalid <= fm_read;
            if (fm_read) fm_readdata <= mem[fm_address[5:2]];
            if (fm_write) wr_cnt <= wr_cnt + 8'h01;
            for (int b = 0; b < 4; b++)
                if (fm_write && fm_byteenable[b]) mem[fm_address[5:2]][8*b+:8] <= fm_writedata[8*b+:8];
        end
        else if (fm_read || fm_write) wait_q <= wait_q + 4'h1;
    end
endmodule : sdcb_fabric_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the single dword completer bridge
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("mismatch at %0t got %h expected %h", $time, a, e); end end
module tb_top;
    logic clk, rst, req_valid, req_ready, cpl_valid, cpl_has_data, cpl_ready, fm_read, fm_write;
    logic fm_readdatavalid, fm_waitrequest, irq_in, msi_req, msi_ack, intx_assert, intx_deassert;
    logic irq_out, reg_wr, reg_rd;
    sdcb_pkg::sdcb_req_e req_kind;
    logic [9:0]  req_len_dw;
    logic [31:0] req_addr, req_data, cpl_data, fm_address, fm_writedata, fm_readdata, reg_wdata, reg_rdata;
    logic [3:0]  req_first_be, fm_byteenable, stall, last_be;
    logic [15:0] req_id, cpl_req_id;
    logic [7:0]  req_tag, cpl_tag, wr_cnt;
    logic [2:0]  cpl_status;
    logic [11:0] reg_addr;
    logic [3:0]  bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
    int          failures, checked, n_as, n_de, n_msi, i;

    sdcb_bridge i_dut (.*);
    sdcb_fabric_model i_fabric (.*);

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        msi_ack <= msi_req && !msi_ack;
        if (msi_req && msi_ack) n_msi++;
        if (intx_assert) n_as++;
        if (intx_deassert) n_de++;
    end

    // ******************************************
    // Access tasks
    // ******************************************
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic reg_w(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_w

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        `CHK(reg_rdata, e)
    endtask : reg_chk

    task automatic send(input sdcb_pkg::sdcb_req_e k, input logic [9:0] n, input logic [31:0] a, input logic [3:0] be);
        int t;
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_len_dw <= n;
        req_addr <= a;
        req_first_be <= be;
        req_tag <= req_tag + 8'h01;
        t = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && ++t < 200);
        req_valid <= 1'b0;
        if (t >= 200) failures++;
    endtask : send

    task automatic wait_cpl(input logic [2:0] st, input logic [31:0] d);
        int t;
        t = 0;
        while (cpl_valid !== 1'b1 && ++t < 200) @(posedge clk);
        if (t >= 200) failures++;
        // Completion must stand while the layer stalls it
        repeat (2) @(posedge clk);
        `CHK(cpl_status, st)
        `CHK(cpl_has_data, st === sdcb_pkg::CPL_SC)
        `CHK(cpl_tag, req_tag)
        `CHK(cpl_req_id, req_id)
        if (st === sdcb_pkg::CPL_SC) `CHK(cpl_data, d)
        cpl_ready <= 1'b1;
        @(posedge clk);
        cpl_ready <= 1'b0;
    endtask : wait_cpl

    // ******************************************
    // Test sequence
    // ******************************************
    initial
    begin
        clk = 1'b0;
        rst <= 1'b1;
        {req_valid, cpl_ready, irq_in, reg_wr, reg_rd, req_len_dw, req_addr, req_first_be} <= '0;
        {reg_addr, reg_wdata, stall, req_tag} <= '0;
        req_kind <= sdcb_pkg::SDCB_REQ_RD;
        req_id <= 16'hBEEF;
        req_data <= 32'hA5C3_1E70;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        reg_chk(sdcb_pkg::CMD_OFS, 32'h0);
        reg_chk(sdcb_pkg::MSI_CTRL_OFS, 32'h0);
        reg_chk(12'h200, 32'h0);
        for (i = 0; i < 7; i++)
        begin
            stall <= i[3:0];
            send(sdcb_pkg::SDCB_REQ_WR, sdcb_pkg::DW_ONE, 32'(4 * i), bes[i]);
            send(sdcb_pkg::SDCB_REQ_RD, sdcb_pkg::DW_ONE, 32'(4 * i), bes[i]);
            wait_cpl(sdcb_pkg::CPL_SC, 32'hA5C3_1E70 & {{8{bes[i][3]}}, {8{bes[i][2]}}, {8{bes[i][1]}}, {8{bes[i][0]}}});
            `CHK(last_be, bes[i])
            `CHK(wr_cnt, 8'(i + 1))
        end
        send(sdcb_pkg::SDCB_REQ_WR, 10'h002, 32'h0, 4'hF);
        send(sdcb_pkg::SDCB_REQ_RD, 10'h002, 32'h0, 4'hF);
        wait_cpl(sdcb_pkg::CPL_CA, 32'h0);
        send(sdcb_pkg::SDCB_REQ_RD, 10'h000, 32'h0, 4'hF);
        wait_cpl(sdcb_pkg::CPL_CA, 32'h0);
        send(sdcb_pkg::SDCB_REQ_OTHER_NP, sdcb_pkg::DW_ONE, 32'h0, 4'hF);
        wait_cpl(sdcb_pkg::CPL_CA, 32'h0);
        send(sdcb_pkg::SDCB_REQ_RD, sdcb_pkg::DW_ONE, 32'h4, 4'h0);
        wait_cpl(sdcb_pkg::CPL_SC, 32'h0);
        `CHK(wr_cnt, 8'h07)
        `CHK(last_be, 4'hF)
        reg_w(sdcb_pkg::IRQ_STAT_OFS, 32'h0);
        reg_chk(sdcb_pkg::IRQ_STAT_OFS, 32'h3);
        `CHK(irq_out, 1'b0)
        reg_w(sdcb_pkg::IRQ_EN_OFS, 32'hF);
        reg_chk(sdcb_pkg::IRQ_EN_OFS, 32'hF);
        `CHK(irq_out, 1'b1)
        reg_w(sdcb_pkg::IRQ_CLR_OFS, 32'h3);
        reg_chk(sdcb_pkg::IRQ_STAT_OFS, 32'h0);
        `CHK(irq_out, 1'b0)
        reg_w(sdcb_pkg::MSI_CTRL_OFS, 32'h0001_0000);
        repeat (16) @(posedge clk);
        irq_in <= 1'b1;
        for (i = 0; i < 50 && n_msi == 0; i++) @(posedge clk);
        irq_in <= 1'b0;
        reg_w(sdcb_pkg::MSI_CTRL_OFS, 32'h0);
        repeat (16) @(posedge clk);
        `CHK(n_msi, 1)
        `CHK(n_as, 0)
        irq_in <= 1'b1;
        for (i = 0; i < 50 && n_as == 0; i++) @(posedge clk);
        irq_in <= 1'b0;
        for (i = 0; i < 50 && n_de == 0; i++) @(posedge clk);
        `CHK(n_as, 1)
        `CHK(n_de, 1)
        reg_w(sdcb_pkg::CMD_OFS, 32'h0000_0400);
        repeat (16) @(posedge clk);
        irq_in <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK(n_as, 1)
        `CHK(n_msi, 1)
        reg_chk(sdcb_pkg::IRQ_STAT_OFS, 32'hC);
        give_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule : tb_top
